// ### hdl/power_down_pkg.sv
// Constants, types and register layout for the power-down mode controller
package power_down_pkg;

  // ---------------------------------------------------------------
  // Register map (offsets are word indices, byte address = 4 x index)
  // ---------------------------------------------------------------
  localparam logic [31:0] STANDBY_CONTROL_INDEX        = 32'hffffff82;
  localparam logic [31:0] STANDBY_CONTROL_SECOND_INDEX = 32'hffffff88;
  localparam logic [31:0] STANDBY_CONTROL_ADDR        = {STANDBY_CONTROL_INDEX[29:0], 2'b00};
  localparam logic [31:0] STANDBY_CONTROL_SECOND_ADDR =
    {STANDBY_CONTROL_SECOND_INDEX[29:0], 2'b00};

  localparam logic [7:0] STANDBY_CONTROL_RESET        = 8'h00;
  localparam logic [7:0] STANDBY_CONTROL_SECOND_RESET = 8'h00;
  // Writable bits of the first register; bits 6, 5 and 3 read as zero
  localparam logic [7:0] STANDBY_CONTROL_WMASK        = 8'h97;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int STANDBY_SELECT_BIT   = 7;
  localparam int CRYSTAL_KEEP_BIT     = 4;
  localparam int TIMER_UNIT_STOP_BIT  = 2;
  localparam int RTC_CLOCK_STOP_BIT   = 1;
  localparam int SERIAL_CLOCK_STOP_BIT = 0;
  localparam int BREAK_STOP_BIT       = 5;
  localparam int DMA_STOP_BIT         = 4;
  localparam int DAC_STOP_BIT         = 3;
  localparam int ADC_STOP_BIT         = 2;
  localparam int FIFO_SERIAL_STOP_BIT = 1;
  localparam int IRDA_STOP_BIT        = 0;

  // ---------------------------------------------------------------
  // Bus answers
  // ---------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    MODE_RUN,
    MODE_SLEEP,
    MODE_STANDBY,
    MODE_WAKE_WAIT,
    MODE_HW_STANDBY
  } pwr_mode_t;

  typedef struct packed {
    logic timerUnit;
    logic rtcInterface;
    logic serialInterface;
    logic breakController;
    logic dma;
    logic dac;
    logic adc;
    logic fifoSerial;
    logic irdaSerial;
  } module_clock_t;

  typedef struct packed {
    logic clockGenRun;
    logic coreHalt;
    logic memSelfRefresh;
    logic rtcCounterRun;
    logic timerPinHold;
    logic serialPinReset;
  } power_state_t;

endpackage

// ### hdl/power_down_mode_controller.sv
// Power-down mode controller with AXI4-Lite register access
`timescale 1ns/1ps
module power_down_mode_controller
  import power_down_pkg::*;
(
  input  wire logic                  clk,
  input  wire logic                  sys_rst,
  input  wire logic                  clkEnable,
  input  wire logic                  manualReset_n,
  input  wire logic                  hwStandbyIn_n,
  input  wire logic                  sleepExec,
  input  wire logic                  interruptAccept,
  input  wire logic                  watchdogOverflow,
  input  wire logic                  rtcStartBit,
  input  wire logic                  timerFromRtc,
  input  wire logic [31:0]           s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [31:0]           s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  output logic                       proc_state_hi,
  output logic                       proc_state_lo,
  output logic                       wakeupOut_n,
  output power_down_pkg::module_clock_t moduleClockRun,
  output power_down_pkg::power_state_t  powerState,
  output logic                       rtcRegAccess
);
  import power_down_pkg::*;

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  logic [2:0] manualSync;
  logic [2:0] hwStandbySync;
  logic       manualResetActive;
  logic       hwStandbyActive;

  // Filtered level changes only once the second and third stages agree
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      manualSync        <= 3'h7;
      hwStandbySync     <= 3'h7;
      manualResetActive <= 1'b0;
      hwStandbyActive   <= 1'b0;
    end
    else if (clkEnable)
    begin
      manualSync <= {manualSync[1:0], manualReset_n};
      hwStandbySync <= {hwStandbySync[1:0], hwStandbyIn_n};
      if (manualSync[1] == manualSync[2])
        manualResetActive <= ~manualSync[2];
      if (hwStandbySync[1] == hwStandbySync[2])
        hwStandbyActive <= ~hwStandbySync[2];
    end
  end

  // ---------------------------------------------------------------
  // Register bus
  // ---------------------------------------------------------------
  logic [7:0]  standbyControl;
  logic [7:0]  standbyControlSecond;
  logic        awHeld;
  logic        wHeld;
  logic [31:0] awAddr;
  logic [31:0] wData;
  logic        wLane0;

  function automatic logic addrHit(input logic [31:0] addr);
    addrHit = (addr == STANDBY_CONTROL_ADDR) || (addr == STANDBY_CONTROL_SECOND_ADDR);
  endfunction

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      awHeld        <= 1'b0;
      wHeld         <= 1'b0;
      awAddr        <= 32'h00000000;
      wData         <= 32'h00000000;
      wLane0        <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
    end
    else if (clkEnable)
    begin
      s_axi_awready <= ~awHeld & ~s_axi_bvalid & ~(s_axi_awvalid & s_axi_awready);
      s_axi_wready  <= ~wHeld & ~s_axi_bvalid & ~(s_axi_wvalid & s_axi_wready);
      if (s_axi_awvalid && s_axi_awready)
      begin
        awHeld <= 1'b1;
        awAddr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        wHeld  <= 1'b1;
        wData  <= s_axi_wdata;
        wLane0 <= s_axi_wstrb[0];
      end
      if (awHeld && wHeld && !s_axi_bvalid)
      begin
        awHeld       <= 1'b0;
        wHeld        <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= addrHit(awAddr) ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // only the power-on reset clears; manual reset leaves contents
  // each register takes its own fixed address, low byte lane
  // reserved bits of the first register never store a one; the second register stores all eight bits
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      standbyControl       <= STANDBY_CONTROL_RESET;
      standbyControlSecond <= STANDBY_CONTROL_SECOND_RESET;
    end
    else if (clkEnable && awHeld && wHeld && !s_axi_bvalid && wLane0)
    begin
      if (awAddr == STANDBY_CONTROL_ADDR)
        standbyControl <= wData[7:0] & STANDBY_CONTROL_WMASK;
      if (awAddr == STANDBY_CONTROL_SECOND_ADDR)
        standbyControlSecond <= wData[7:0];
    end
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= RESP_OKAY;
    end
    else if (clkEnable)
    begin
      s_axi_arready <= ~s_axi_rvalid & ~(s_axi_arvalid & s_axi_arready);
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= addrHit(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
        if (s_axi_araddr == STANDBY_CONTROL_ADDR)
          s_axi_rdata <= {24'h000000, standbyControl};
        else if (s_axi_araddr == STANDBY_CONTROL_SECOND_ADDR)
          s_axi_rdata <= {24'h000000, standbyControlSecond};
        else
          s_axi_rdata <= 32'h00000000;
      end
      else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Mode sequencer
  // ---------------------------------------------------------------
  pwr_mode_t mode;

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      mode <= MODE_RUN;
    else if (clkEnable)
    begin
      case (mode)
        MODE_RUN:
        begin
          // select bit picks sleep or standby
          if (sleepExec)
            mode <= standbyControl[STANDBY_SELECT_BIT] ? MODE_STANDBY : MODE_SLEEP;
        end
        MODE_SLEEP:
        begin
          if (interruptAccept)
            mode <= MODE_RUN;
        end
        MODE_STANDBY:
        begin
          // wake source seen, wait for oscillator settling
          if (interruptAccept)
            mode <= MODE_WAKE_WAIT;
        end
        MODE_WAKE_WAIT:
        begin
          if (watchdogOverflow)
            mode <= MODE_RUN;
        end
        MODE_HW_STANDBY:
          mode <= MODE_HW_STANDBY;
        default:
          mode <= MODE_RUN;
      endcase
      // manual reset leaves sleep and standby
      if (manualResetActive && mode != MODE_HW_STANDBY)
        mode <= MODE_RUN;
      // pin wins over everything; only power-on reset leaves
      if (hwStandbyActive)
        mode <= MODE_HW_STANDBY;
    end
  end

  // ---------------------------------------------------------------
  // Registered outputs
  // ---------------------------------------------------------------
  logic deepStop;
  logic hwStop;
  logic next_rtcRun;
  logic next_timerRun;

  always_comb
  begin
    deepStop = (mode == MODE_STANDBY) || (mode == MODE_WAKE_WAIT) ||
               (mode == MODE_HW_STANDBY);
    hwStop   = (mode == MODE_HW_STANDBY);
    // RTC survives both standby kinds only when started
    next_rtcRun   = !deepStop || rtcStartBit;
    // RTC-fed timer survives plain standby only
    next_timerRun = !standbyControl[TIMER_UNIT_STOP_BIT] &&
                    (!deepStop || (!hwStop && timerFromRtc && rtcStartBit));
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      proc_state_hi <= 1'b1;
      proc_state_lo <= 1'b1;
    end
    else if (clkEnable)
    begin
      // HH reset, HL sleep, LH standby, LL normal
      if (manualResetActive && !hwStop)
      begin
        proc_state_hi <= 1'b1;
        proc_state_lo <= 1'b1;
      end
      else
      begin
        proc_state_hi <= (mode == MODE_SLEEP);
        proc_state_lo <= deepStop;
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      wakeupOut_n <= 1'b1;
    else if (clkEnable)
      // low from accepted wakeup until watchdog overflow returns
      wakeupOut_n <= ~((mode == MODE_WAKE_WAIT) ||
                       (mode == MODE_STANDBY && interruptAccept)) | manualResetActive;
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      moduleClockRun <= '1;
      rtcRegAccess   <= 1'b1;
    end
    else if (clkEnable)
    begin
      // each stop bit gates one module, clearing restores it
      moduleClockRun.timerUnit       <= next_timerRun;
      // interface clock gated, counter kept apart below
      moduleClockRun.rtcInterface    <= !standbyControl[RTC_CLOCK_STOP_BIT] && !deepStop;
      rtcRegAccess                   <= !standbyControl[RTC_CLOCK_STOP_BIT] && !deepStop;
      moduleClockRun.serialInterface <= !standbyControl[SERIAL_CLOCK_STOP_BIT] && !deepStop;
      moduleClockRun.breakController <= !standbyControlSecond[BREAK_STOP_BIT] && !deepStop;
      moduleClockRun.dma             <= !standbyControlSecond[DMA_STOP_BIT] && !deepStop;
      moduleClockRun.dac             <= !standbyControlSecond[DAC_STOP_BIT] && !deepStop;
      moduleClockRun.adc             <= !standbyControlSecond[ADC_STOP_BIT] && !deepStop;
      moduleClockRun.fifoSerial      <= !standbyControlSecond[FIFO_SERIAL_STOP_BIT] && !deepStop;
      moduleClockRun.irdaSerial      <= !standbyControlSecond[IRDA_STOP_BIT] && !deepStop;
    end
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      powerState <= '{clockGenRun: 1'b1, coreHalt: 1'b0, memSelfRefresh: 1'b0,
                      rtcCounterRun: 1'b1, timerPinHold: 1'b0, serialPinReset: 1'b0};
    else if (clkEnable)
    begin
      // crystal-keep holds the generator in plain standby only
      // hardware standby always halts the generator
      powerState.clockGenRun    <= !deepStop ||
                                   (!hwStop && standbyControl[CRYSTAL_KEEP_BIT]);
      // core halted in every power-down mode
      powerState.coreHalt       <= (mode != MODE_RUN);
      // memory refresh moves to self-refresh while clocks stop
      powerState.memSelfRefresh <= deepStop;
      // counter independent of the interface gate
      powerState.rtcCounterRun  <= next_rtcRun;
      // stopped timer keeps its pin, stopped serial resets its pin
      powerState.timerPinHold   <= standbyControl[TIMER_UNIT_STOP_BIT];
      powerState.serialPinReset <= standbyControl[SERIAL_CLOCK_STOP_BIT];
    end
  end

endmodule

// ### tb/power_down_chk.sv
// Checker of mode pins, wake output and bus answers
`timescale 1ns/1ps
module power_down_chk
  import power_down_pkg::*;
(
  input wire logic                          clk,
  input wire logic                          sys_rst,
  input wire logic                          clkEnable,
  input wire logic                          manualReset_n,
  input wire logic                          hwStandbyIn_n,
  input wire logic                          sleepExec,
  input wire logic                          interruptAccept,
  input wire logic                          watchdogOverflow,
  input wire logic                          s_axi_arvalid,
  input wire logic                          s_axi_arready,
  input wire logic [1:0]                    s_axi_bresp,
  input wire logic                          s_axi_bvalid,
  input wire logic                          s_axi_bready,
  input wire logic                          s_axi_rvalid,
  input wire logic                          proc_state_hi,
  input wire logic                          proc_state_lo,
  input wire logic                          wakeupOut_n,
  input wire power_down_pkg::module_clock_t moduleClockRun,
  input wire power_down_pkg::power_state_t  powerState
);
  logic [1:0] ps;
  assign ps = {proc_state_hi, proc_state_lo};
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // Pin standby ends only by power-on reset, so wake checks stop there
  logic hwSeen;
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      hwSeen <= 1'b0;
    else if (!hwStandbyIn_n)
      hwSeen <= 1'b1;
  end
  // ----
  // Mode entry and exit
  // ----
  sleep_entry_a: assert property (
    sleepExec && ps == 2'b00 && clkEnable && manualReset_n && hwStandbyIn_n
    |-> ##[2:3] ps inside {2'b10, 2'b01}) else $error("sleep not entered");
  wake_fall_a: assert property (
    interruptAccept && ps == 2'b01 && wakeupOut_n && hwStandbyIn_n && clkEnable && !hwSeen
    |-> ##[1:2] !wakeupOut_n) else $error("wake output not low");
  wake_hold_a: assert property (
    !watchdogOverflow[*2] ##1 (!wakeupOut_n && !watchdogOverflow && manualReset_n && !hwSeen)
    |=> !wakeupOut_n) else $error("wake output released early");
  wdt_exit_a: assert property (
    !wakeupOut_n && watchdogOverflow && clkEnable
    |-> ##[2:3] (ps == 2'b00 && wakeupOut_n)) else $error("no return to run");
  // ----
  // Mode outputs
  // ----
  sleep_pins_a: assert property (ps == 2'b10 |->
    powerState.coreHalt && powerState.clockGenRun && !powerState.memSelfRefresh)
    else $error("bad sleep outputs");
  standby_pins_a: assert property (ps == 2'b01 |->
    powerState.coreHalt && powerState.memSelfRefresh && !moduleClockRun.serialInterface
    && !moduleClockRun.dma) else $error("bad standby outputs");
  run_pins_a: assert property (ps == 2'b00 |->
    !powerState.coreHalt && powerState.timerPinHold == !moduleClockRun.timerUnit
    && powerState.serialPinReset == !moduleClockRun.serialInterface)
    else $error("bad run outputs");
  // ----
  // Register bus
  // ----
  resp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped");
  read_answer_a: assert property (s_axi_arvalid && s_axi_arready && clkEnable
    |-> ##[1:2] s_axi_rvalid) else $error("read answer late");
  cover property (ps == 2'b10);
  cover property ($fell(wakeupOut_n));
  cover property (!hwStandbyIn_n && ps == 2'b01);
  cover property (s_axi_bvalid && s_axi_bresp == RESP_SLVERR);
endmodule

bind power_down_mode_controller power_down_chk u_chk (.*);

// ### tb/core_model.sv
// Behavioural core issuing sleep, interrupt and watchdog pulses
`timescale 1ns/1ps
module core_model
(
  input  wire logic clk,
  output logic      sleepExec,
  output logic      interruptAccept,
  output logic      watchdogOverflow
);
  initial {sleepExec, interruptAccept, watchdogOverflow} = 3'b000;
  task automatic pulse(input int which, input int gap);
    repeat (gap) @(posedge clk);
    case (which)
      0: sleepExec <= 1'b1;
      1: interruptAccept <= 1'b1;
      default: watchdogOverflow <= 1'b1;
    endcase
    @(posedge clk);
    {sleepExec, interruptAccept, watchdogOverflow} <= 3'b000;
  endtask
endmodule

// ### tb/power_down_mode_controller_bench.sv
// Self-checking bench of the power-down mode controller
`timescale 1ns/1ps
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin bad_count++; \
  $display("Error %0t got %h exp %h", $time, a, e); end end
module power_down_mode_controller_bench;
  import power_down_pkg::*;
  logic clk, sys_rst, clkEnable, manualReset_n, hwStandbyIn_n, rtcStartBit, timerFromRtc;
  logic sleepExec, interruptAccept, watchdogOverflow;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, seed, rd;
  logic [3:0] s_axi_wstrb;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic proc_state_hi, proc_state_lo, wakeupOut_n, rtcRegAccess;
  logic [7:0] r1, r2;
  module_clock_t moduleClockRun;
  power_state_t powerState;
  int bad_count, check_count, cycles;

  power_down_mode_controller u_power_down_mode_controller (.*);
  core_model u_core_model (.clk(clk), .sleepExec(sleepExec),
    .interruptAccept(interruptAccept), .watchdogOverflow(watchdogOverflow));

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Generous ceiling; the run needs under 2000 cycles
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 8000)
    begin
      bad_count++;
      end_sim();
    end
  end

  function automatic logic [31:0] xs(logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction

  function automatic module_clock_t expRun(logic [7:0] a, b);
    return ~{a[2:0], b[5:0]};
  endfunction

  task automatic wr(input logic [31:0] a, input logic [7:0] d);
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {seed[31:8], d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic rdt(input logic [31:0] a);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  task automatic chk_reg(input logic [31:0] a, input logic [7:0] e);
    rdt(a);
    `CHK({rsp, rd}, {RESP_OKAY, 24'h0, e})
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  initial
  begin
    seed = 32'h38f1bd50;
    {clkEnable, manualReset_n, hwStandbyIn_n, rtcStartBit, timerFromRtc} = 5'b11100;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'b0;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
    s_axi_wstrb = 4'hf;
    sys_rst = 1'b1;
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
    chk_reg(STANDBY_CONTROL_ADDR, 8'h00);
    chk_reg(STANDBY_CONTROL_SECOND_ADDR, 8'h00);
    rdt(STANDBY_CONTROL_ADDR + 32'h4);
    `CHK({rsp, rd}, {RESP_SLVERR, 32'h0})
    wr(32'h10, 8'hff);
    `CHK(rsp, RESP_SLVERR)
    wr(STANDBY_CONTROL_ADDR, 8'hff);
    chk_reg(STANDBY_CONTROL_ADDR, 8'h97);
    // ----
    // Random stop bits, sleep and wake by interrupt
    // ----
    repeat (8)
    begin
      seed = xs(seed);
      r1 = seed[7:0] & 8'h17;
      r2 = seed[15:8];
      wr(STANDBY_CONTROL_ADDR, r1);
      wr(STANDBY_CONTROL_SECOND_ADDR, r2);
      chk_reg(STANDBY_CONTROL_SECOND_ADDR, r2);
      `CHK(moduleClockRun, expRun(r1, r2))
      `CHK(rtcRegAccess, ~r1[1])
      `CHK(powerState, {4'b1001, r1[2], r1[0]})
      u_core_model.pulse(0, 1 + seed[17:16]);
      repeat (4) @(posedge clk);
      `CHK({proc_state_hi, proc_state_lo}, 2'b10)
      `CHK(moduleClockRun, expRun(r1, r2))
      u_core_model.pulse(1, 1 + seed[19:18]);
      repeat (4) @(posedge clk);
      `CHK({proc_state_hi, proc_state_lo}, 2'b00)
    end
    // ----
    // Standby with crystal and counter options
    // ----
    for (int i = 0; i < 4; i++)
    begin
      rtcStartBit <= i[1];
      timerFromRtc <= 1'b1;
      wr(STANDBY_CONTROL_ADDR, {1'b1, 2'b00, i[0], 4'b0000});
      u_core_model.pulse(0, 2);
      repeat (4) @(posedge clk);
      `CHK({proc_state_hi, proc_state_lo}, 2'b01)
      `CHK(powerState[5:2], {i[0], 2'b11, i[1]})
      `CHK(moduleClockRun, {i[1], 8'h00})
      u_core_model.pulse(1, 1);
      repeat (8) @(posedge clk);
      `CHK(wakeupOut_n, 1'b0)
      u_core_model.pulse(2, 1);
      repeat (4) @(posedge clk);
      `CHK({proc_state_hi, proc_state_lo, wakeupOut_n}, 3'b001)
    end
    wr(STANDBY_CONTROL_ADDR, 8'h15);
    manualReset_n <= 1'b0;
    repeat (6) @(posedge clk);
    `CHK({proc_state_hi, proc_state_lo}, 2'b11)
    manualReset_n <= 1'b1;
    repeat (6) @(posedge clk);
    chk_reg(STANDBY_CONTROL_ADDR, 8'h15);
    // ----
    // Frozen clock enable and an unselected byte lane
    // ----
    clkEnable <= 1'b0;
    u_core_model.pulse(0, 1);
    repeat (4) @(posedge clk);
    `CHK({proc_state_hi, proc_state_lo}, 2'b00)
    clkEnable <= 1'b1;
    repeat (2) @(posedge clk);
    `CHK({proc_state_hi, proc_state_lo}, 2'b00)
    s_axi_wstrb <= 4'he;
    wr(STANDBY_CONTROL_ADDR, 8'h80);
    `CHK(rsp, RESP_OKAY)
    s_axi_wstrb <= 4'hf;
    chk_reg(STANDBY_CONTROL_ADDR, 8'h15);
    // ----
    // Pin-driven standby, left only by power-on reset
    // ----
    rtcStartBit <= 1'b1;
    hwStandbyIn_n <= 1'b0;
    repeat (8) @(posedge clk);
    `CHK({proc_state_hi, proc_state_lo}, 2'b01)
    `CHK(powerState[5:2], 4'b0111)
    `CHK(moduleClockRun.timerUnit, 1'b0)
    hwStandbyIn_n <= 1'b1;
    repeat (8) @(posedge clk);
    `CHK({proc_state_hi, proc_state_lo}, 2'b01)
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    chk_reg(STANDBY_CONTROL_ADDR, 8'h00);
    `CHK({proc_state_hi, proc_state_lo}, 2'b00)
    end_sim();
  end
endmodule
